// >>> rtl/uesc_pkg.sv
// constants for the usb error, status and control register block
package uesc_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_ERR_FLAGS  = 8'h00;
    localparam logic [7:0] OFF_ERR_EN     = 8'h04;
    localparam logic [7:0] OFF_STATUS     = 8'h08;
    localparam logic [7:0] OFF_CONTROL    = 8'h0c;
    localparam logic [7:0] OFF_EVT_FLAGS  = 8'h10;
    localparam logic [7:0] OFF_EVT_EN     = 8'h14;

    // ------------------------------------------------------------------
    // error flag / enable bit positions
    // ------------------------------------------------------------------
    localparam int ERR_PID    = 0;
    localparam int ERR_TOKCRC = 1;
    localparam int ERR_CRC16  = 2;
    localparam int ERR_DFN8   = 3;
    localparam int ERR_TA     = 4;
    localparam int ERR_DMA    = 5;
    localparam int ERR_BMX    = 6;
    localparam int ERR_STUFF  = 7;

    // ------------------------------------------------------------------
    // status, control and event bit positions
    // ------------------------------------------------------------------
    localparam int STAT_ENDP_LSB = 4;
    localparam int STAT_DIR      = 3;
    localparam int STAT_ODD      = 2;
    localparam int CTL_LIVE_J    = 7;
    localparam int CTL_LIVE_SE0  = 6;
    localparam int CTL_PKT_DIS   = 5;
    localparam int CTL_BUS_RST   = 4;
    localparam int CTL_HOST      = 3;
    localparam int CTL_RESUME    = 2;
    localparam int CTL_BANK_RST  = 1;
    localparam int CTL_ENABLE    = 0;
    localparam int EVT_TRN       = 3;
    localparam int EVT_ERR       = 1;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam int          TA_IDLE_BITS = 16;
    localparam int          FIFO_DEPTH   = 4;

    typedef enum logic [1:0] {
        UESC_TA_IDLE = 2'b00,
        UESC_TA_WAIT = 2'b01,
        UESC_TA_FLAG = 2'b11
    } uesc_ta_e;
endpackage

// >>> rtl/uesc_top.sv
// usb error flags, error enables, transfer status fifo and module control over apb
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
//
// Summary of operation
// - device mode: token crc5 failure sets error flag bit 1
// - host mode: bit 1 flags frame-start countdown expiring during traffic
// - pid check failure sets error flag bit 0
// - late dma grant or truncated receive sets the dma error flag
// - over 16 idle bit times after eop without response sets timeout
// - error enable bits 7..0 gate flags at matching positions
// - enable bit 1 gates crc5 in device mode, eof in host mode
// - enabled errors reach module interrupt only with error interrupt enable set
// - status bits 7..4 give endpoint of the oldest unread completed transfer
// - status bit 3 is one for transmit, zero for receive
// - status bit 2 shows odd bank; bits 1..0 read zero
// - status is head of four-entry fifo; clearing transfer flag pops it
// - control bit 7 reads live j state
// - control bit 6 reads live single-ended zero
// - device mode: bit 5 disables packets, set by hardware on setup
// - host mode: bit 5 reads one while a token executes
// - control bit 3 enables host; each change resets host logic
// - resume bit drives resume; host clear appends low-speed eop
// - bits 31..8 of the six registers read zero
// - error flags set by hardware, cleared only by writing one
// - summary error flag set only by enabled error conditions
// - bit 1 resets bank pointers; bit 0 module or frame-start enable
module uesc_top #(
    parameter int FIFO_DEPTH = uesc_pkg::FIFO_DEPTH,
    parameter int TA_BITS    = uesc_pkg::TA_IDLE_BITS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pid_check_fail,
    input  wire logic        token_crc5_fail,
    input  wire logic        sof_count_zero,
    input  wire logic        link_active,
    input  wire logic        data_crc16_fail,
    input  wire logic        data_field_size_fail,
    input  wire logic        dma_grant_late,
    input  wire logic        rx_buffer_overrun,
    input  wire logic        bd_address_invalid,
    input  wire logic        bit_stuff_fail,
    input  wire logic        bit_time_tick,
    input  wire logic        eop_expect_response,
    input  wire logic        response_start,
    input  wire logic        xfer_done,
    input  wire logic [3:0]  xfer_endpoint,
    input  wire logic        xfer_transmit,
    input  wire logic        xfer_odd_bank,
    input  wire logic        setup_token_rx,
    input  wire logic        token_in_progress,
    input  wire logic        live_j_state,
    input  wire logic        live_single_ended_zero,
    output logic             xfer_stall,
    output logic             module_interrupt_flag,
    output logic             packet_processing_disable,
    output logic             bus_reset_drive,
    output logic             host_capability_enable,
    output logic             host_logic_reset,
    output logic             resume_drive,
    output logic             low_speed_eop,
    output logic             bank_pointer_reset,
    output logic             module_enable,
    output logic             frame_start_enable
);
    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_depth_chk
        $error("fifo depth must be a power of two of at least 2");
    end
    if (TA_BITS < 1 || TA_BITS > 250) begin : g_ta_chk
        $error("turnaround bit count out of range");
    end

    // ------------------------------------------------------------------
    // apb slave: zero wait states, answer one cycle after setup
    // ------------------------------------------------------------------
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        setup;
    logic        acc_wr;
    logic        hit;
    logic        wr_err;
    logic        wr_en;
    logic        wr_ctl;
    logic        wr_evt;
    logic        wr_ie;
    logic [31:0] rd_word;

    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pwrite & pready_q;

    always_comb begin
        hit = 1'b1;
        if (paddr == uesc_pkg::OFF_ERR_FLAGS) begin
            hit = 1'b1;
        end else if (paddr == uesc_pkg::OFF_ERR_EN) begin
            hit = 1'b1;
        end else if (paddr == uesc_pkg::OFF_STATUS) begin
            hit = 1'b1;
        end else if (paddr == uesc_pkg::OFF_CONTROL) begin
            hit = 1'b1;
        end else if (paddr == uesc_pkg::OFF_EVT_FLAGS) begin
            hit = 1'b1;
        end else if (paddr == uesc_pkg::OFF_EVT_EN) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_err = acc_wr & (paddr == uesc_pkg::OFF_ERR_FLAGS);
    assign wr_en  = acc_wr & (paddr == uesc_pkg::OFF_ERR_EN);
    assign wr_ctl = acc_wr & (paddr == uesc_pkg::OFF_CONTROL);
    assign wr_evt = acc_wr & (paddr == uesc_pkg::OFF_EVT_FLAGS);
    assign wr_ie  = acc_wr & (paddr == uesc_pkg::OFF_EVT_EN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= uesc_pkg::RST_WORD;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q  <= (setup & ~pwrite) ? rd_word : uesc_pkg::RST_WORD;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic [5:0] ctl_q;
    logic       pkt_dis_q;
    logic       host;

    assign host = ctl_q[uesc_pkg::CTL_HOST];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 6'h00;
        end else if (wr_ctl) begin
            ctl_q <= pwdata[5:0];
        end
    end

    // hardware set on setup beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_dis_q <= 1'b0;
        end else if (!host && setup_token_rx) begin
            pkt_dis_q <= 1'b1;
        end else if (wr_ctl) begin
            pkt_dis_q <= pwdata[uesc_pkg::CTL_PKT_DIS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_processing_disable <= 1'b0;
            bus_reset_drive           <= 1'b0;
            host_capability_enable    <= 1'b0;
            host_logic_reset          <= 1'b0;
            resume_drive              <= 1'b0;
            low_speed_eop             <= 1'b0;
            bank_pointer_reset        <= 1'b0;
            module_enable             <= 1'b0;
            frame_start_enable        <= 1'b0;
        end else begin
            packet_processing_disable <= ~host & pkt_dis_q;
            bus_reset_drive           <= host & ctl_q[uesc_pkg::CTL_BUS_RST];
            host_capability_enable    <= host;
            host_logic_reset          <= wr_ctl & (pwdata[uesc_pkg::CTL_HOST] != host);
            resume_drive              <= ctl_q[uesc_pkg::CTL_RESUME];
            // host mode only: eop appended when resume goes from one to zero
            low_speed_eop             <= wr_ctl & host & ctl_q[uesc_pkg::CTL_RESUME]
                                         & ~pwdata[uesc_pkg::CTL_RESUME];
            bank_pointer_reset        <= wr_ctl & pwdata[uesc_pkg::CTL_BANK_RST];
            module_enable             <= ~host & ctl_q[uesc_pkg::CTL_ENABLE];
            frame_start_enable        <= host & ctl_q[uesc_pkg::CTL_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // turnaround timeout detector
    // ------------------------------------------------------------------
    uesc_pkg::uesc_ta_e ta_state_q;
    logic [7:0]         ta_cnt_q;

    // a new eop restarts the wait; a response start cancels it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_state_q <= uesc_pkg::UESC_TA_IDLE;
            ta_cnt_q   <= 8'h00;
        end else begin
            case (ta_state_q)
                uesc_pkg::UESC_TA_IDLE: begin
                    ta_cnt_q <= 8'h00;
                    if (eop_expect_response) begin
                        ta_state_q <= uesc_pkg::UESC_TA_WAIT;
                    end
                end
                uesc_pkg::UESC_TA_WAIT: begin
                    if (response_start) begin
                        ta_state_q <= uesc_pkg::UESC_TA_IDLE;
                    end else if (eop_expect_response) begin
                        ta_cnt_q <= 8'h00;
                    end else if (bit_time_tick) begin
                        if (ta_cnt_q == 8'(TA_BITS)) begin
                            ta_state_q <= uesc_pkg::UESC_TA_FLAG;
                        end else begin
                            ta_cnt_q <= ta_cnt_q + 8'h01;
                        end
                    end
                end
                default: begin
                    ta_state_q <= uesc_pkg::UESC_TA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // error flags, enables and summary
    // ------------------------------------------------------------------
    logic [7:0] err_evt;
    logic [7:0] err_flags_q;
    logic [7:0] err_en_q;
    logic       err_ie_q;
    logic       summary_q;

    always_comb begin
        err_evt                       = 8'h00;
        err_evt[uesc_pkg::ERR_PID]    = pid_check_fail;
        err_evt[uesc_pkg::ERR_TOKCRC] = host ? (sof_count_zero & link_active)
                                             : token_crc5_fail;
        err_evt[uesc_pkg::ERR_CRC16]  = data_crc16_fail;
        err_evt[uesc_pkg::ERR_DFN8]   = data_field_size_fail;
        err_evt[uesc_pkg::ERR_TA]     = ta_state_q == uesc_pkg::UESC_TA_FLAG;
        err_evt[uesc_pkg::ERR_DMA]    = dma_grant_late | rx_buffer_overrun;
        err_evt[uesc_pkg::ERR_BMX]    = bd_address_invalid;
        err_evt[uesc_pkg::ERR_STUFF]  = bit_stuff_fail;
    end

    for (genvar i = 0; i < 8; i++) begin : g_err
        // set wins over a write-one clear landing in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                err_flags_q[i] <= 1'b0;
            end else if (err_evt[i]) begin
                err_flags_q[i] <= 1'b1;
            end else if (wr_err && pwdata[i]) begin
                err_flags_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_en_q <= uesc_pkg::RST_BYTE;
            err_ie_q <= 1'b0;
        end else begin
            if (wr_en) begin
                err_en_q <= pwdata[7:0];
            end
            if (wr_ie) begin
                err_ie_q <= pwdata[uesc_pkg::EVT_ERR];
            end
        end
    end

    // one mask covers bit 1 in both modes since the flag meaning follows the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_q             <= 1'b0;
            module_interrupt_flag <= 1'b0;
        end else begin
            summary_q             <= |(err_flags_q & err_en_q);
            module_interrupt_flag <= |(err_flags_q & err_en_q) & err_ie_q;
        end
    end

    // ------------------------------------------------------------------
    // transfer status fifo
    // ------------------------------------------------------------------
    logic [5:0]  fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0]   count_q;
    logic [PW:0]   count_d;
    logic          push;
    logic          pop;
    logic          trn_flag;

    assign trn_flag = count_q != '0;
    assign push     = xfer_done & ~xfer_stall;
    assign pop      = wr_evt & pwdata[uesc_pkg::EVT_TRN] & trn_flag;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            xfer_stall <= 1'b0;
        end else begin
            count_q    <= count_d;
            xfer_stall <= count_d == (PW + 1)'(FIFO_DEPTH);
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // storage needs no reset; entries are read only while counted
    always_ff @(posedge pclk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= {xfer_endpoint, xfer_transmit, xfer_odd_bank};
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [7:0] ctl_rd;

    always_comb begin
        ctl_rd                          = {2'b00, ctl_q};
        ctl_rd[uesc_pkg::CTL_LIVE_J]    = live_j_state;
        ctl_rd[uesc_pkg::CTL_LIVE_SE0]  = live_single_ended_zero;
        ctl_rd[uesc_pkg::CTL_PKT_DIS]   = host ? token_in_progress : pkt_dis_q;
        rd_byte = uesc_pkg::RST_BYTE;
        if (paddr == uesc_pkg::OFF_ERR_FLAGS) begin
            rd_byte = err_flags_q;
        end else if (paddr == uesc_pkg::OFF_ERR_EN) begin
            rd_byte = err_en_q;
        end else if (paddr == uesc_pkg::OFF_STATUS) begin
            // endpoint, direction, bank; low two bits zero; zero when empty
            rd_byte = trn_flag ? {fifo_mem[rd_ptr_q], 2'b00} : 8'h00;
        end else if (paddr == uesc_pkg::OFF_CONTROL) begin
            rd_byte = ctl_rd;
        end else if (paddr == uesc_pkg::OFF_EVT_FLAGS) begin
            rd_byte = {4'h0, trn_flag, 1'b0, summary_q, 1'b0};
        end else if (paddr == uesc_pkg::OFF_EVT_EN) begin
            rd_byte = {6'h00, err_ie_q, 1'b0};
        end
        rd_word = {24'h00_0000, rd_byte};
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pid_flag_set: assert property (pid_check_fail |=> err_flags_q[0])
        else $error("pid failure did not set flag");
    a_crc5_dev_set: assert property (!host && token_crc5_fail |=> err_flags_q[1])
        else $error("token crc failure did not set flag");
    a_eof_host_set: assert property (host && sof_count_zero && link_active |=> err_flags_q[1])
        else $error("end of frame error not flagged");
    a_dma_flag_set: assert property ((dma_grant_late || rx_buffer_overrun) |=> err_flags_q[5])
        else $error("dma error not flagged");
    a_ta_count_full: assert property ($rose(ta_state_q == uesc_pkg::UESC_TA_FLAG)
        |-> ta_cnt_q == 8'(TA_BITS) ##1 err_flags_q[4])
        else $error("turnaround timeout at wrong count");
    a_irq_gate_out: assert property (##1 module_interrupt_flag
        == $past(|(err_flags_q & err_en_q) && err_ie_q))
        else $error("interrupt output not gated by enables");
    a_w1c_zero_keep: assert property (wr_err && !pwdata[0] && err_flags_q[0] |=> err_flags_q[0])
        else $error("writing zero cleared a flag");
    a_fifo_full_stall: assert property (xfer_stall |-> count_q == (PW + 1)'(FIFO_DEPTH))
        else $error("stall without full fifo");
    a_setup_pkt_dis: assert property (!host && setup_token_rx |=> ##1 packet_processing_disable)
        else $error("setup did not disable packets");
    a_read_high_zero: assert property (pready_q && psel && penable && !pwrite |-> prdata_q[31:8] == 24'h0)
        else $error("upper read bits not zero");

    c_fifo_full: cover property (xfer_stall && xfer_done);
    c_err_irq: cover property ($rose(module_interrupt_flag));
    c_ta_timeout: cover property (ta_state_q == uesc_pkg::UESC_TA_FLAG);
    c_pop_push: cover property (push && pop);
endmodule

// >>> sim/uesc_peer.sv
// usb bus peer model: line state, bit time ticks and turnaround responses
`timescale 1ns/1ps
module uesc_peer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] line,
    input  wire logic       respond,
    input  wire logic       eop_seen,
    output logic            tick,
    output logic            resp,
    output logic            j_state,
    output logic            se0
);
    // ------------------------------------------------------------------
    // bit timing and answers
    // ------------------------------------------------------------------
    logic [1:0] div_q;
    logic       arm_q;
    assign j_state = line == 2'h2;
    assign se0     = line == 2'h0;
    // one bit time every four pclk, 100 ns with the testbench clock
    assign tick    = div_q == 2'h3;
    // answer on the next bit time, well inside the idle limit
    assign resp    = tick & arm_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            arm_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            arm_q <= (arm_q | (eop_seen & respond)) & ~resp;
        end
    end
endmodule

// >>> sim/tb_top.sv
// testbench: apb access sequences against the usb error, status and control block
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd, x;
    logic        pready, pslverr, serr, tick, resp, jst, se0, stall, mif, ppd;
    logic        brd, hce, hlr, rsm, lse, bpr, men, fse;
    logic [11:0] ev = 12'h000;
    logic [3:0]  ep = 4'h0;
    logic        tx = 1'b0, odd = 1'b0, tip = 1'b0, lact = 1'b0, respond = 1'b0;
    logic [1:0]  line = 2'h2;
    int          failures = 0, check_count = 0, nhlr = 0, nlse = 0, nbpr = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) nhlr <= nhlr + int'(hlr);
    always @(posedge pclk) nlse <= nlse + int'(lse);
    always @(posedge pclk) nbpr <= nbpr + int'(bpr);
    uesc_peer uesc_peer_inst (.pclk, .presetn, .line, .respond, .eop_seen(ev[9]), .tick, .resp,
        .j_state(jst), .se0);
    uesc_top #(.TA_BITS(2)) uesc_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .pid_check_fail(ev[0]), .token_crc5_fail(ev[1]),
        .sof_count_zero(ev[4]), .link_active(lact), .data_crc16_fail(ev[2]),
        .data_field_size_fail(ev[3]), .dma_grant_late(ev[5]), .rx_buffer_overrun(ev[8]),
        .bd_address_invalid(ev[6]), .bit_stuff_fail(ev[7]), .bit_time_tick(tick),
        .eop_expect_response(ev[9]), .response_start(resp), .xfer_done(ev[11]),
        .xfer_endpoint(ep), .xfer_transmit(tx), .xfer_odd_bank(odd), .setup_token_rx(ev[10]),
        .token_in_progress(tip), .live_j_state(jst), .live_single_ended_zero(se0),
        .xfer_stall(stall), .module_interrupt_flag(mif), .packet_processing_disable(ppd),
        .bus_reset_drive(brd), .host_capability_enable(hce), .host_logic_reset(hlr),
        .resume_drive(rsm), .low_speed_eop(lse), .bank_pointer_reset(bpr),
        .module_enable(men), .frame_start_enable(fse));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // idle edge first, so psel is never lowered and raised in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask
    task automatic push(input logic [3:0] e, input logic t, input logic o);
        @(posedge pclk);
        ep <= e;
        tx <= t;
        odd <= o;
        ev[11] <= 1'b1;
        @(posedge pclk);
        ev[11] <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        end_of_test();
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) rdchk(8'(a), 32'hffff_ff7f, 32'h0);
        chk(32'(serr), 32'h1);
        for (int i = 0; i < 9; i++) if (i != 4) begin
            x = 32'h1 << (i == 8 ? 5 : i);
            pulse(i);
            apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, ~x);
            rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'hffff_ffff, x);
            apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, x);
            rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'hffff_ffff, 32'h0);
        end
        apb(1'b1, uesc_pkg::OFF_ERR_EN, 32'hffff_ff01);
        rdchk(uesc_pkg::OFF_ERR_EN, 32'hffff_ffff, 32'h1);
        pulse(1);
        rdchk(uesc_pkg::OFF_EVT_FLAGS, 32'h2, 32'h0);
        pulse(0);
        rdchk(uesc_pkg::OFF_EVT_FLAGS, 32'h2, 32'h2);
        chk(32'(mif), 32'h0);
        apb(1'b1, uesc_pkg::OFF_EVT_EN, 32'h2);
        repeat (2) @(posedge pclk);
        chk(32'(mif), 32'h1);
        // drop the crc5 flag so only the unenabled pid flag stays set
        apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, 32'h2);
        apb(1'b1, uesc_pkg::OFF_ERR_EN, 32'h2);
        repeat (2) @(posedge pclk);
        chk(32'(mif), 32'h0);
        apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, 32'hff);
        apb(1'b1, uesc_pkg::OFF_CONTROL, 32'h08);
        lact <= 1'b1;
        pulse(4);
        rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'hffff_ffff, 32'h2);
        chk(32'(mif), 32'h1);
        apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, 32'hff);
        lact <= 1'b0;
        pulse(4);
        pulse(1);
        rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'hffff_ffff, 32'h0);
        tip <= 1'b1;
        rdchk(uesc_pkg::OFF_CONTROL, 32'h20, 32'h20);
        tip <= 1'b0;
        rdchk(uesc_pkg::OFF_CONTROL, 32'h20, 32'h0);
        apb(1'b1, uesc_pkg::OFF_CONTROL, 32'h1f);
        repeat (2) @(posedge pclk);
        chk(32'({brd, hce, rsm, men, fse}), 32'h1d);
        apb(1'b1, uesc_pkg::OFF_CONTROL, 32'h09); // resume hold shortened to keep the run short
        apb(1'b1, uesc_pkg::OFF_CONTROL, 32'h04);
        apb(1'b1, uesc_pkg::OFF_CONTROL, 32'h00);
        repeat (2) @(posedge pclk);
        chk(32'(nlse), 32'h1);
        chk(32'(nbpr), 32'h1);
        chk(32'(nhlr), 32'h2);
        pulse(10);
        rdchk(uesc_pkg::OFF_CONTROL, 32'h20, 32'h20);
        chk(32'(ppd), 32'h1);
        line <= 2'h0;
        rdchk(uesc_pkg::OFF_CONTROL, 32'hc0, 32'h40);
        line <= 2'h2;
        rdchk(uesc_pkg::OFF_CONTROL, 32'hc0, 32'h80);
        pulse(9);
        repeat (40) @(posedge pclk);
        rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'h10, 32'h10);
        apb(1'b1, uesc_pkg::OFF_ERR_FLAGS, 32'hff);
        respond <= 1'b1;
        pulse(9);
        repeat (40) @(posedge pclk);
        rdchk(uesc_pkg::OFF_ERR_FLAGS, 32'h10, 32'h0);
        for (int k = 0; k < 4; k++) push(4'(k * 5), k[0], k[1]);
        @(posedge pclk);
        chk(32'(stall), 32'h1);
        push(4'h3, 1'b1, 1'b1);
        for (int k = 0; k < 4; k++) begin
            rdchk(uesc_pkg::OFF_STATUS, 32'hffff_ffff, {24'h0, 4'(k * 5), k[0], k[1], 2'h0});
            rdchk(uesc_pkg::OFF_EVT_FLAGS, 32'h8, 32'h8);
            apb(1'b1, uesc_pkg::OFF_EVT_FLAGS, 32'h8);
        end
        rdchk(uesc_pkg::OFF_EVT_FLAGS, 32'h8, 32'h0);
        chk(32'(stall), 32'h0);
        end_of_test();
    end
endmodule
